// file: design/bandgap_trim_regs.sv
//==============================================================================
// bandgap trim, reference and temperature sensor select, APB register bank
//
// Design decisions made here: the register offsets and the APB register port.
module bandgap_trim_regs
	import bandgap_trim_pkg::*;
#(
	parameter int ADC_W = 10
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// analog trims
	output logic [3:0] level_trim_code_o,
	output logic [3:0] curve_trim_code_o,
	// brown-out detector
	output logic [3:0] brownout_level_o,
	output logic brownout_update_o,
	// adc, dac and comparators
	output logic [1:0] reference_select_o,
	output logic [3:0] adc_input_select_o,
	output logic temp_sensor_en_o,
	input wire logic [ADC_W-1:0] adc_result_i,
	input wire logic adc_done_i,
	// signature row
	output logic sig_rd_o,
	output logic [7:0] sig_addr_o,
	input wire logic [7:0] sig_data_i
);

	//==========================================================================
	// parameter check
	generate
		if (ADC_W < 8 || ADC_W > 12)
		begin : g_bad_width
			$error("adc width must be 8 to 12");
		end
	endgenerate

	//==========================================================================
	// functions
	function automatic logic is_thermo(input logic [3:0] code);
		is_thermo = (code == 4'h0) || (code == 4'h1) || (code == 4'h3) ||
			(code == 4'h7) || (code == 4'hF);
	endfunction : is_thermo

	function automatic logic [2:0] ones(input logic [3:0] code);
		ones = 3'(code[0]) + 3'(code[1]) + 3'(code[2]) + 3'(code[3]);
	endfunction : ones

	//==========================================================================
	// state
	logic [7:0] level_ff;
	logic [7:0] curve_ff;
	logic [7:0] chsel_ff;
	logic [7:0] gain_ff;
	logic [6:0] offset_ff;
	logic cal_ready_ff;
	cal_state_t cal_state_ff;
	cal_state_t nxt_cal_state;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [3:0] bod_level_ff;
	logic bod_update_ff;
	logic temp_en_ff;
	logic sig_rd_ff;
	logic [7:0] sig_addr_ff;
	logic [15:0] temp_ff;

	temp_conv_if #(.ADC_W(ADC_W)) tc ();

	//==========================================================================
	// bus decode
	wire logic setup_ph;
	wire logic commit;
	wire logic wr_commit;
	wire logic hit_level;
	wire logic hit_curve;
	wire logic hit_chsel;
	wire logic hit_cal;
	wire logic hit_status;
	wire logic mapped;
	wire logic ro_hit;

	assign setup_ph = psel_i && !penable_i;
	// no wait state: pready rises in the access phase that follows setup
	assign commit = psel_i && penable_i && pready_ff;
	assign wr_commit = commit && pwrite_i;
	assign hit_level = (paddr_i == LEVEL_TRIM_OFS);
	assign hit_curve = (paddr_i == CURVE_TRIM_OFS);
	assign hit_chsel = (paddr_i == ADC_CHSEL_OFS);
	assign hit_cal = (paddr_i == CAL_OFS);
	assign hit_status = (paddr_i == STATUS_OFS);
	assign mapped = hit_level || hit_curve || hit_chsel || hit_cal || hit_status;
	assign ro_hit = hit_cal || hit_status;

	//==========================================================================
	// register next values
	wire logic [7:0] nxt_level;
	wire logic [7:0] nxt_curve;
	wire logic [7:0] nxt_chsel;
	wire logic level_change;
	wire logic [3:0] insel;
	wire logic [1:0] refsel;

	// level and curve trim upper nibble is held at zero whatever is written
	assign nxt_level = {4'h0, pwdata_i[3:0] & TRIM_FIELD_MASK};
	assign nxt_curve = {4'h0, pwdata_i[3:0] & TRIM_FIELD_MASK};
	assign nxt_chsel = {pwdata_i[REFSEL_LSB+:2], 2'h0, pwdata_i[INSEL_LSB+:4]};
	assign level_change = wr_commit && hit_level && (nxt_level != level_ff);
	assign insel = chsel_ff[INSEL_LSB+:4];
	assign refsel = chsel_ff[REFSEL_LSB+:2];

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			level_ff <= TRIM_RESET;
			curve_ff <= TRIM_RESET;
			chsel_ff <= CHSEL_RESET;
		end
		else if (wr_commit)
		begin
			if (hit_level)
				level_ff <= nxt_level;
			if (hit_curve)
				curve_ff <= nxt_curve;
			if (hit_chsel)
				chsel_ff <= nxt_chsel;
		end
	end

	//==========================================================================
	// brown-out threshold follows the level trim
	// the detector sees the new code on the commit edge, together with the level trim
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bod_level_ff <= TRIM_RESET[3:0];
			bod_update_ff <= 1'b0;
		end
		else
		begin
			bod_update_ff <= level_change;
			if (level_change)
				bod_level_ff <= nxt_level[3:0];
		end
	end

	//==========================================================================
	// temperature sensor enable
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			temp_en_ff <= 1'b0;
		else
			temp_en_ff <= (insel == TEMP_SENSOR_CH);
	end

	//==========================================================================
	// calibration fetch from the signature row after reset
	// data returns the cycle after the read strobe
	always_comb
	begin
		nxt_cal_state = cal_state_ff;
		unique case (cal_state_ff)
			CAL_OFS_REQ: nxt_cal_state = CAL_OFS_CAP;
			CAL_OFS_CAP: nxt_cal_state = CAL_GAIN_REQ;
			CAL_GAIN_REQ: nxt_cal_state = CAL_GAIN_CAP;
			CAL_GAIN_CAP: nxt_cal_state = CAL_DONE;
			CAL_DONE: nxt_cal_state = CAL_DONE;
			default: nxt_cal_state = CAL_OFS_REQ;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cal_state_ff <= CAL_OFS_REQ;
			sig_rd_ff <= 1'b0;
			sig_addr_ff <= 8'h00;
			gain_ff <= 8'h00;
			offset_ff <= 7'h00;
			cal_ready_ff <= 1'b0;
		end
		else
		begin
			cal_state_ff <= nxt_cal_state;
			sig_rd_ff <= (cal_state_ff == CAL_OFS_REQ) || (cal_state_ff == CAL_GAIN_REQ);
			if (cal_state_ff == CAL_OFS_REQ)
				sig_addr_ff <= SIG_ADDR_OFFSET;
			else if (cal_state_ff == CAL_GAIN_REQ)
				sig_addr_ff <= SIG_ADDR_GAIN;
			if (cal_state_ff == CAL_GAIN_REQ)
				offset_ff <= sig_data_i[6:0];
			if (cal_state_ff == CAL_DONE && !cal_ready_ff)
			begin
				gain_ff <= sig_data_i;
				cal_ready_ff <= 1'b1;
			end
		end
	end

	//==========================================================================
	// temperature conversion
	// results only count while the sensor channel and 2.56V reference are both live
	wire logic ref_ok;

	assign ref_ok = (refsel == REF_INT_2V56);
	assign tc.adc_result = adc_result_i;
	assign tc.adc_done = adc_done_i && temp_en_ff && ref_ok && cal_ready_ff;
	assign tc.gain = gain_ff;
	assign tc.offset = offset_ff;

	temp_converter #(
		.ADC_W(ADC_W)
	) u_conv (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tc(tc.conv)
	);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			temp_ff <= 16'h0000;
		else if (tc.temp_valid)
			temp_ff <= tc.temp_c;
	end

	//==========================================================================
	// read mux
	wire logic [31:0] rd_level;
	wire logic [31:0] rd_curve;
	wire logic [31:0] rd_chsel;
	wire logic [31:0] rd_cal;
	wire logic [31:0] rd_status;
	wire logic [31:0] rd_mux;
	wire logic [7:0] step_mv;
	wire logic [2:0] peak_idx;

	// reference moves about 5 mV per code
	assign step_mv = 8'(level_ff[3:0] * LEVEL_STEP_MV);
	// 0 ones: peak hottest, 4 ones: peak coldest
	assign peak_idx = ones(curve_ff[3:0]);
	assign rd_level = {24'h000000, level_ff};
	assign rd_curve = {24'h000000, curve_ff};
	assign rd_chsel = {24'h000000, chsel_ff};
	assign rd_cal = {15'h0000, cal_ready_ff, 1'b0, offset_ff, gain_ff};
	assign rd_status = {step_mv, 2'h0, peak_idx, is_thermo(curve_ff[3:0]), ref_ok,
		temp_en_ff, temp_ff};
	assign rd_mux = hit_level ? rd_level :
		hit_curve ? rd_curve :
		hit_chsel ? rd_chsel :
		hit_cal ? rd_cal :
		hit_status ? rd_status : 32'h00000000;

	//==========================================================================
	// apb response
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prdata_ff <= 32'h00000000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= setup_ph;
			if (setup_ph)
			begin
				prdata_ff <= pwrite_i ? 32'h00000000 : rd_mux;
				// unmapped addresses and writes to read-only words are refused
				pslverr_ff <= !mapped || (pwrite_i && ro_hit);
			end
			else
			begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	//==========================================================================
	// outputs
	assign prdata_o = prdata_ff;
	assign pready_o = pready_ff;
	assign pslverr_o = pslverr_ff;
	assign level_trim_code_o = level_ff[3:0];
	assign curve_trim_code_o = curve_ff[3:0];
	assign brownout_level_o = bod_level_ff;
	assign brownout_update_o = bod_update_ff;
	assign reference_select_o = chsel_ff[REFSEL_LSB+:2];
	assign adc_input_select_o = chsel_ff[INSEL_LSB+:4];
	assign temp_sensor_en_o = temp_en_ff;
	assign sig_rd_o = sig_rd_ff;
	assign sig_addr_o = sig_addr_ff;

endmodule : bandgap_trim_regs

// file: include/bandgap_trim_pkg.sv
//==============================================================================
package bandgap_trim_pkg;

	//==========================================================================
	// register map (byte addresses)
	localparam logic [7:0] LEVEL_TRIM_OFS = 8'h00;
	localparam logic [7:0] CURVE_TRIM_OFS = 8'h04;
	localparam logic [7:0] ADC_CHSEL_OFS = 8'h08;
	localparam logic [7:0] CAL_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;

	//==========================================================================
	// field positions and reset values
	localparam logic [7:0] TRIM_RESET = 8'h08;
	localparam logic [3:0] TRIM_FIELD_MASK = 4'hF;
	localparam int INSEL_LSB = 0;
	localparam int REFSEL_LSB = 6;
	localparam logic [7:0] CHSEL_RESET = 8'h00;
	localparam int CAL_GAIN_LSB = 0;
	localparam int CAL_OFS_LSB = 8;
	localparam int CAL_READY_BIT = 16;
	localparam int ST_TEMP_LSB = 0;
	localparam int ST_SENSOR_EN_BIT = 16;
	localparam int ST_REF_OK_BIT = 17;
	localparam int ST_CURVE_OK_BIT = 18;
	localparam int ST_PEAK_LSB = 19;
	localparam int ST_STEP_MV_LSB = 24;

	//==========================================================================
	// analog codes and scaling
	localparam logic [3:0] TEMP_SENSOR_CH = 4'hC;
	localparam logic [1:0] REF_INT_2V56 = 2'h3;
	localparam logic [7:0] LEVEL_STEP_MV = 8'h05;
	localparam int KELVIN_OFS = 273;
	localparam int CAL_ROOM_C = 25;
	localparam int GAIN_FRAC_BITS = 7;
	localparam logic [7:0] SIG_ADDR_OFFSET = 8'h05;
	localparam logic [7:0] SIG_ADDR_GAIN = 8'h07;

	typedef enum logic [2:0] {
		CAL_OFS_REQ = 3'h0,
		CAL_OFS_CAP = 3'h1,
		CAL_GAIN_REQ = 3'h2,
		CAL_GAIN_CAP = 3'h3,
		CAL_DONE = 3'h4
	} cal_state_t;

endpackage : bandgap_trim_pkg

// file: include/temp_conv_if.sv
//==============================================================================
// carrier between the register bank and the temperature converter
interface temp_conv_if #(
	parameter int ADC_W = 10
);
	logic [ADC_W-1:0] adc_result;
	logic adc_done;
	logic [7:0] gain;
	logic [6:0] offset;
	logic [15:0] temp_c;
	logic temp_valid;

	modport bank (
		output adc_result,
		output adc_done,
		output gain,
		output offset,
		input temp_c,
		input temp_valid
	);

	modport conv (
		input adc_result,
		input adc_done,
		input gain,
		input offset,
		output temp_c,
		output temp_valid
	);
endinterface : temp_conv_if

// file: design/temp_converter.sv
//==============================================================================
// degrees C = ((adc - (298 - offset)) * gain) / 128 + 25
module temp_converter
	import bandgap_trim_pkg::*;
#(
	parameter int ADC_W = 10
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// bank side
	temp_conv_if.conv tc
);

	localparam int DIFF_W = ADC_W + 3;
	localparam int PROD_W = DIFF_W + 9;

	wire logic signed [DIFF_W-1:0] adc_s;
	wire logic signed [DIFF_W-1:0] ofs_s;
	wire logic signed [DIFF_W-1:0] diff;
	wire logic signed [PROD_W-1:0] prod;
	wire logic signed [PROD_W-1:0] scaled;
	wire logic signed [PROD_W-1:0] result;
	logic [15:0] temp_ff;
	logic valid_ff;

	assign adc_s = DIFF_W'($signed({1'b0, tc.adc_result}));
	assign ofs_s = DIFF_W'($signed(tc.offset));
	assign diff = adc_s - DIFF_W'(KELVIN_OFS + CAL_ROOM_C) + ofs_s;
	// gain is unsigned, so widen with a zero sign bit
	assign prod = PROD_W'(diff) * PROD_W'($signed({1'b0, tc.gain}));
	assign scaled = prod >>> GAIN_FRAC_BITS;
	assign result = scaled + PROD_W'(CAL_ROOM_C);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			temp_ff <= 16'h0000;
			valid_ff <= 1'b0;
		end
		else
		begin
			valid_ff <= tc.adc_done;
			if (tc.adc_done)
				temp_ff <= result[15:0];
		end
	end

	assign tc.temp_c = temp_ff;
	assign tc.temp_valid = valid_ff;

endmodule : temp_converter

// file: tb/bandgap_trim_regs_asserts.sv
//==============================================================================
// port checks for the trim register bank
module bandgap_trim_regs_asserts
	import bandgap_trim_pkg::*;
#(
	parameter int ADC_W = 10
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// analog controls
	input wire logic [3:0] level_trim_code_o,
	input wire logic [3:0] curve_trim_code_o,
	input wire logic [3:0] brownout_level_o,
	input wire logic brownout_update_o,
	input wire logic [1:0] reference_select_o,
	input wire logic [3:0] adc_input_select_o,
	input wire logic temp_sensor_en_o,
	// signature row
	input wire logic sig_rd_o,
	input wire logic [7:0] sig_addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_done;
		psel_i && penable_i && pready_o;
	endsequence
	sequence s_wr_level;
		s_done ##0 pwrite_i && paddr_i == LEVEL_TRIM_OFS;
	endsequence
	sequence s_wr_chsel;
		s_done ##0 pwrite_i && paddr_i == ADC_CHSEL_OFS;
	endsequence

	//==========================================================================
	// bus
	chk_ready_wait: assert property (s_setup |=> pready_o)
		else $error("no ready after setup");
	chk_ready_only: assert property (pready_o |-> $past(psel_i && !penable_i))
		else $error("ready without setup");
	chk_ro_refused: assert property (s_done ##0 pwrite_i &&
		(paddr_i == CAL_OFS || paddr_i == STATUS_OFS) |-> pslverr_o)
		else $error("read-only write accepted");
	//==========================================================================
	// trims; reset is checked while held, so no disable here
	chk_trim_reset: assert property (disable iff (1'b0) !rst_n_i |->
		level_trim_code_o == 4'h8 && curve_trim_code_o == 4'h8)
		else $error("trim reset value wrong");
	chk_level_write: assert property (s_wr_level |=>
		level_trim_code_o == $past(pwdata_i[3:0])) else $error("level trim not stored");
	chk_curve_write: assert property (s_done ##0 pwrite_i && paddr_i == CURVE_TRIM_OFS |=>
		curve_trim_code_o == $past(pwdata_i[3:0])) else $error("curve trim not stored");
	chk_trim_upper: assert property (s_done ##0 !pwrite_i &&
		(paddr_i == LEVEL_TRIM_OFS || paddr_i == CURVE_TRIM_OFS) |-> prdata_o[31:4] == 28'h0)
		else $error("trim upper bits not zero");
	chk_brownout_pulse: assert property (s_wr_level ##0
		pwdata_i[3:0] != level_trim_code_o |-> ##[1:3] brownout_update_o)
		else $error("brownout update missing");
	chk_brownout_track: assert property (brownout_update_o |->
		brownout_level_o == level_trim_code_o) else $error("brownout level stale");
	//==========================================================================
	// adc select and calibration fetch
	chk_refsel_write: assert property (s_wr_chsel |=>
		reference_select_o == $past(pwdata_i[7:6]) &&
		adc_input_select_o == $past(pwdata_i[3:0])) else $error("chsel not stored");
	chk_sensor_on: assert property ((adc_input_select_o == TEMP_SENSOR_CH)[*2] |->
		temp_sensor_en_o) else $error("sensor not enabled");
	chk_sensor_off: assert property ((adc_input_select_o != TEMP_SENSOR_CH)[*2] |->
		!temp_sensor_en_o) else $error("sensor enabled on other channel");
	chk_sig_order: assert property (sig_rd_o && sig_addr_o == SIG_ADDR_OFFSET |->
		##2 sig_rd_o && sig_addr_o == SIG_ADDR_GAIN) else $error("calibration fetch order");
endmodule : bandgap_trim_regs_asserts

bind bandgap_trim_regs bandgap_trim_regs_asserts #(.ADC_W(ADC_W)) bandgap_trim_regs_asserts_i (
	.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
	.pready_o, .pslverr_o, .level_trim_code_o, .curve_trim_code_o, .brownout_level_o,
	.brownout_update_o, .reference_select_o, .adc_input_select_o, .temp_sensor_en_o,
	.sig_rd_o, .sig_addr_o);

// file: tb/tb_bandgap_trim_regs.sv
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (x)); end end

module tb_bandgap_trim_regs
	import bandgap_trim_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// -4 degrees offset, gain of exactly one
	localparam logic [6:0] CAL_OFFSET = 7'h7C;
	localparam logic [7:0] CAL_GAIN = 8'h80;
	logic clk_i = 1'b0, rst_n_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00, sig_data_i = 8'h00, sig_addr_o;
	logic [31:0] pwdata_i = 32'h0, prdata_o, q;
	logic [9:0] adc_result_i = 10'h000;
	logic adc_done_i = 1'b0, pready_o, pslverr_o, brownout_update_o, temp_sensor_en_o, sig_rd_o, e;
	logic [3:0] level_trim_code_o, curve_trim_code_o, brownout_level_o, adc_input_select_o;
	logic [1:0] reference_select_o;
	int miscompares = 0;
	int compares = 0;

	always #5 clk_i = ~clk_i;
	// signature row: other addresses toggle so a stray capture shows
	always @(posedge clk_i)
		sig_data_i <= (sig_addr_o == SIG_ADDR_OFFSET) ? {1'b0, CAL_OFFSET} :
			(sig_addr_o == SIG_ADDR_GAIN) ? CAL_GAIN : ~sig_data_i;

	bandgap_trim_regs #(.ADC_W(10)) bandgap_trim_regs_i (.clk_i, .rst_n_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .level_trim_code_o,
		.curve_trim_code_o, .brownout_level_o, .brownout_update_o, .reference_select_o,
		.adc_input_select_o, .temp_sensor_en_o, .adc_result_i, .adc_done_i, .sig_rd_o,
		.sig_addr_o, .sig_data_i);

	//==========================================================================
	// bus and stimulus tasks
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask : apb

	task automatic adc(input logic [9:0] v);
		adc_result_i <= v;
		adc_done_i <= 1'b1;
		@(posedge clk_i);
		adc_done_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		apb(1'b0, STATUS_OFS, 32'h0);
	endtask : adc

	//==========================================================================
	// scenarios
	task automatic t_reset;
		apb(1'b0, LEVEL_TRIM_OFS, 32'h0);
		`CHK(q, 32'h00000008)
		apb(1'b0, CURVE_TRIM_OFS, 32'h0);
		`CHK(q, 32'h00000008)
		apb(1'b0, CAL_OFS, 32'h0);
		`CHK(q[16:0], {2'b10, CAL_OFFSET, CAL_GAIN})
		`CHK({sig_rd_o, sig_addr_o}, {1'b0, SIG_ADDR_GAIN})
	endtask : t_reset

	task automatic t_level;
		logic [3:0] codes [3] = '{4'h0, 4'hF, 4'h5};
		foreach (codes[i])
		begin
			apb(1'b1, LEVEL_TRIM_OFS, {28'hFFFFFFF, codes[i]});
			// pulse set on the commit edge, still visible one edge later
			`CHK(brownout_update_o, 1'b1)
			repeat (2) @(posedge clk_i);
			`CHK(brownout_update_o, 1'b0)
			`CHK(level_trim_code_o, codes[i])
			`CHK(brownout_level_o, codes[i])
			apb(1'b0, LEVEL_TRIM_OFS, 32'h0);
			`CHK(q, {28'h0, codes[i]})
			apb(1'b0, STATUS_OFS, 32'h0);
			`CHK(q[31:24], 8'(codes[i] * LEVEL_STEP_MV))
		end
	endtask : t_level

	task automatic t_curve;
		logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
		foreach (codes[i])
		begin
			apb(1'b1, CURVE_TRIM_OFS, {28'hFFFFFFF, codes[i]});
			`CHK(curve_trim_code_o, codes[i])
			apb(1'b0, CURVE_TRIM_OFS, 32'h0);
			`CHK(q, {28'h0, codes[i]})
			apb(1'b0, STATUS_OFS, 32'h0);
			`CHK(q[21:18], {3'(i), 1'b1})
		end
		apb(1'b1, CURVE_TRIM_OFS, 32'h5);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK(q[18], 1'b0)
	endtask : t_curve

	task automatic t_sensor;
		apb(1'b1, ADC_CHSEL_OFS, {24'h0, REF_INT_2V56, 2'b11, TEMP_SENSOR_CH});
		apb(1'b0, ADC_CHSEL_OFS, 32'h0);
		`CHK(q, {24'h0, REF_INT_2V56, 2'b00, TEMP_SENSOR_CH})
		`CHK(temp_sensor_en_o, 1'b1)
		`CHK(reference_select_o, REF_INT_2V56)
		`CHK(adc_input_select_o, TEMP_SENSOR_CH)
		adc(10'h15E);
		`CHK(q[17:0], {2'b11, 16'h0049})
		apb(1'b1, ADC_CHSEL_OFS, {24'h0, REF_INT_2V56, 6'h0B});
		// sensor enable lags the select by one edge
		@(posedge clk_i);
		`CHK(temp_sensor_en_o, 1'b0)
		adc(10'h190);
		`CHK(q[16:0], {1'b0, 16'h0049})
	endtask : t_sensor

	task automatic t_errors;
		apb(1'b0, 8'h14, 32'h0);
		`CHK({e, q}, {1'b1, 32'h0})
		apb(1'b1, CAL_OFS, 32'hFFFFFFFF);
		`CHK(e, 1'b1)
		apb(1'b0, CAL_OFS, 32'h0);
		`CHK(q[16:0], {2'b10, CAL_OFFSET, CAL_GAIN})
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		apb(1'b0, LEVEL_TRIM_OFS, 32'h0);
		`CHK(q, 32'h00000008)
	endtask : t_errors

	task automatic end_of_test;
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		// a real falling edge at time zero, so the flops are reset before the first clock
		rst_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_reset();
		t_level();
		t_curve();
		t_sensor();
		t_errors();
		end_of_test();
	end

	initial
	begin
		#50us;
		miscompares++;
		end_of_test();
	end
endmodule : tb_bandgap_trim_regs
